//--- dv/difl_host_model.sv
// host bus master model for the register port
`timescale 1ns/10ps
module difl_host_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        // unused mode bit always written as zero
        reg_wdata <= (a == 4'h0 || a == 4'h8) ? d & 8'hF7 : d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

//--- dv/difl_top_properties.sv
// port-level assertions for the fifo-level interrupt block
`timescale 1ns/10ps
module difl_top_properties #(
    parameter int CHANNELS = 2,
    parameter int DEPTH = 8,
    parameter int BIT_TIMES = 64
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire difl_pkg::difl_chan_in_type chan_in [CHANNELS],
    input wire logic [3:0] change_input,
    input wire logic counter_ready,
    input wire difl_pkg::difl_chan_out_type chan_out [CHANNELS],
    input wire logic [15:0] count_preload,
    input wire logic irq
);
    logic [7:0] pre_hi;
    logic [7:0] pre_lo;
    assign pre_hi = count_preload[15:8];
    assign pre_lo = count_preload[7:0];
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_mask_off;
        reg_wr && reg_addr == 4'h5 && reg_wdata == 8'h00;
    endsequence
    sequence s_mask_kept;
        !(reg_wr && reg_addr == 4'h5);
    endsequence
    a_mask_gates_irq: assert property (
        s_mask_off ##1 s_mask_kept |=> !irq)
        else $error("irq high with mask cleared");
    a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_preload_high: assert property (reg_wr && reg_addr == 4'h6 |=>
        pre_hi == $past(reg_wdata) && $stable(pre_lo))
        else $error("preload high byte wrong");
    a_preload_low: assert property (reg_wr && reg_addr == 4'h7 |=>
        pre_lo == $past(reg_wdata) && $stable(pre_hi))
        else $error("preload low byte wrong");
    a_rx_empty_quiet: assert property (
        (chan_in[0].rx_count == 4'h0) [*2] |=> !chan_out[0].rx_irq_req)
        else $error("rx request with empty fifo");
    a_rx_full_req: assert property (chan_in[0].rx_count == 4'h8
        |=> chan_out[0].rx_irq_req)
        else $error("no rx request with full fifo");
    a_tx_disabled: assert property (!chan_in[0].tx_enable
        |=> !chan_out[0].tx_irq_req)
        else $error("tx request while disabled");
    a_tx_full_quiet: assert property (chan_in[0].tx_count == 4'h8
        |=> !chan_out[0].tx_irq_req)
        else $error("tx request with no empty slot");
    a_baud_legal: assert property (
        chan_out[0].baud_group inside {3'h0, 3'h1, 3'h4})
        else $error("forbidden baud group");
    a_chan_b_baud: assert property (chan_out[1].baud_group == 3'h0)
        else $error("channel b baud bits not zero");
    a_reset_values: assert property ($fell(reset) |->
        count_preload == 16'h0000 && !irq)
        else $error("wrong value after reset");
endmodule

bind difl_top difl_top_properties #(.CHANNELS(CHANNELS), .DEPTH(DEPTH),
    .BIT_TIMES(BIT_TIMES)) u_difl_top_properties (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_in(chan_in),
    .change_input(change_input), .counter_ready(counter_ready),
    .chan_out(chan_out), .count_preload(count_preload), .irq(irq));

//--- dv/tb_difl_top.sv
// self-checking testbench for the fifo-level interrupt block
`timescale 1ns/10ps
module tb_difl_top;
    localparam int BT = 4;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic counter_ready = 1'b0;
    logic irq;
    logic [3:0] change_input = 4'h5;
    logic [3:0] nv;
    logic [15:0] count_preload;
    logic [7:0] d;
    logic [7:0] w;
    logic [7:0] v;
    logic [2:0] grp;
    logic [1:0] k;
    difl_pkg::difl_chan_in_type chan_in [2] = '{default: '0};
    difl_pkg::difl_chan_out_type chan_out [2];
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    difl_host_model u_difl_host_model (.clk(clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd));
    difl_top #(.BIT_TIMES(BT)) u_difl_top (.clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_in(chan_in),
        .change_input(change_input), .counter_ready(counter_ready),
        .chan_out(chan_out), .count_preload(count_preload), .irq(irq));
    // ----
    // helpers
    // ----
    function automatic logic rx_exp(input logic [1:0] c, input int n);
        case (c)
            2'h0: return n >= 1;
            2'h1: return n >= 3;
            2'h2: return n >= 6;
            default: return n == 8;
        endcase
    endfunction
    function automatic logic tx_exp(input logic [1:0] c, input int n);
        case (c)
            2'h0: return 8 - n == 8;
            2'h1: return 8 - n >= 4;
            2'h2: return 8 - n >= 6;
            default: return 8 - n >= 1;
        endcase
    endfunction
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // pointer must be at zero before every mode register access
    task automatic mode_wr(input int c, input logic [7:0] x);
        @(posedge clk) chan_in[c].ptr_to_mr0 <= 1'b1;
        @(posedge clk) chan_in[c].ptr_to_mr0 <= 1'b0;
        u_difl_host_model.wr(c ? 4'h8 : 4'h0, x);
    endtask
    task automatic mode_rd(input int c, output logic [7:0] x);
        @(posedge clk) chan_in[c].ptr_to_mr0 <= 1'b1;
        @(posedge clk) chan_in[c].ptr_to_mr0 <= 1'b0;
        u_difl_host_model.rd(c ? 4'h8 : 4'h0, x);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            $display("[FAIL] timeout expected done seen hang");
            results();
        end
    end
    // ----
    // tests
    // ----
    initial begin
        d = $urandom(41);
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        tick(2);
        u_difl_host_model.rd(4'hB, d);
        chk("mask", 8'h00, d);
        u_difl_host_model.rd(4'h3, d);
        chk("unmapped", 8'h00, d);
        u_difl_host_model.wr(4'h0, 8'hC1);
        mode_rd(0, d);
        chk("mode reset", 8'h00, d);
        $display("test reset done");
        repeat (6) begin
            w = $urandom;
            v = $urandom;
            u_difl_host_model.wr(4'h6, w);
            u_difl_host_model.wr(4'h7, v);
            tick(1);
            chk("preload", {w, v}, count_preload);
        end
        $display("test preload done");
        grp = 3'h0;
        for (int i = 0; i < 8; i++) begin
            w = {1'b0, 7'($urandom)};
            w[2:0] = 3'(i);
            mode_wr(0, w);
            if (i == 0 || i == 1 || i == 4) grp = 3'(i);
            tick(1);
            chk("baud a", grp, chan_out[0].baud_group);
            mode_rd(0, d);
            chk("mode a", {w[7:4], 1'b0}, d[7:3]);
            mode_wr(1, w);
            mode_rd(1, d);
            chk("mode b", w & 8'hF0, d);
        end
        $display("test mode done");
        for (int c = 0; c < 4; c++) begin
            k = 2'(c);
            mode_wr(0, {1'b0, k[1], k, 4'h0});
            for (int n = 0; n <= 8; n++) begin
                @(posedge clk);
                chan_in[0].rx_level_lsb <= k[0];
                chan_in[0].rx_count <= 4'(n);
                chan_in[0].tx_count <= 4'(n);
                chan_in[0].tx_enable <= 1'b1;
                tick(3);
                chk("rx req", rx_exp(k, n), chan_out[0].rx_irq_req);
                chk("tx req", tx_exp(k, n), chan_out[0].tx_irq_req);
            end
        end
        $display("test levels done");
        @(posedge clk);
        chan_in[0].tx_enable <= 1'b0;
        chan_in[0].rx_count <= 4'h0;
        chan_in[0].tx_count <= 4'h0;
        mode_wr(0, 8'h00);
        u_difl_host_model.wr(4'hA, 8'hFF);
        u_difl_host_model.wr(4'h5, 8'h08);
        @(posedge clk) counter_ready <= 1'b1;
        @(posedge clk) counter_ready <= 1'b0;
        tick(2);
        chk("irq counter", 1'b1, irq);
        u_difl_host_model.wr(4'hA, 8'h08);
        tick(2);
        chk("irq cleared", 1'b0, irq);
        u_difl_host_model.wr(4'h5, 8'h00);
        @(posedge clk);
        chan_in[0].break_change <= 1'b1;
        chan_in[1].break_change <= 1'b1;
        @(posedge clk);
        chan_in[0].break_change <= 1'b0;
        chan_in[1].break_change <= 1'b0;
        tick(2);
        chk("irq masked", 1'b0, irq);
        u_difl_host_model.rd(4'h5, d);
        chk("status break", 8'h44, d);
        u_difl_host_model.wr(4'hA, 8'hFF);
        u_difl_host_model.wr(4'h5, 8'h01);
        @(posedge clk) chan_in[0].tx_enable <= 1'b1;
        tick(3);
        chk("irq tx empty", 1'b1, irq);
        @(posedge clk) chan_in[0].tx_count <= 4'h1;
        tick(3);
        chk("tx withdrawn", 1'b0, chan_out[0].tx_irq_req);
        u_difl_host_model.wr(4'hA, 8'h01);
        tick(2);
        chk("irq tx clear", 1'b0, irq);
        $display("test irq done");
        u_difl_host_model.rd(4'h4, d);
        chk("change idle", {4'h0, change_input}, d);
        nv = change_input ^ 4'(1 + $urandom % 15);
        @(posedge clk) change_input <= nv;
        tick(2);
        u_difl_host_model.rd(4'h4, d);
        chk("change seen", {nv ^ 4'h5, nv}, d);
        u_difl_host_model.rd(4'h4, d);
        chk("change cleared", {4'h0, nv}, d);
        u_difl_host_model.rd(4'h5, d);
        chk("status change", 1'b1, d[7]);
        $display("test input change done");
        mode_wr(0, 8'hC0);
        @(posedge clk);
        chan_in[0].rx_level_lsb <= 1'b1;
        chan_in[0].rx_count <= 4'h2;
        for (int t = 1; t <= BT; t++) begin
            @(posedge clk) chan_in[0].rx_bit_tick <= 1'b1;
            @(posedge clk) chan_in[0].rx_bit_tick <= 1'b0;
            tick(3);
            chk("watchdog", t == BT, chan_out[0].rx_irq_req);
        end
        @(posedge clk) chan_in[0].rx_fifo_access <= 1'b1;
        @(posedge clk) chan_in[0].rx_fifo_access <= 1'b0;
        tick(3);
        chk("watchdog reset", 1'b0, chan_out[0].rx_irq_req);
        chk("watchdog on", 1'b1, chan_out[0].watchdog_on);
        // pointer moved on to mr1: mode address must refuse the read
        @(posedge clk) chan_in[0].ptr_to_mr0 <= 1'b1;
        @(posedge clk) begin
            chan_in[0].ptr_to_mr0 <= 1'b0;
            chan_in[0].ptr_to_mr1 <= 1'b1;
        end
        @(posedge clk) chan_in[0].ptr_to_mr1 <= 1'b0;
        u_difl_host_model.rd(4'h0, d);
        chk("mode ptr mr1", 8'h00, d);
        @(posedge clk);
        chan_in[1].rx_count <= 4'h8;
        chan_in[1].tx_enable <= 1'b1;
        tick(3);
        chk("rx req b", 1'b1, chan_out[1].rx_irq_req);
        chk("tx req b", 1'b1, chan_out[1].tx_irq_req);
        u_difl_host_model.rd(4'h5, d);
        chk("status b", 2'h3, d[5:4]);
        $display("test watchdog done");
        results();
    end
endmodule

//--- verilog/difl_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef DIFL_CONSTS_SVH
`define DIFL_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------------
`define DIFL_OFF_MODE_A 4'h0
`define DIFL_OFF_INPUT_CHANGE 4'h4
`define DIFL_OFF_IRQ 4'h5
`define DIFL_OFF_PRELOAD_HIGH 4'h6
`define DIFL_OFF_PRELOAD_LOW 4'h7
`define DIFL_OFF_MODE_B 4'h8
`define DIFL_OFF_IRQ_CLEAR 4'hA
`define DIFL_OFF_MASK_READ 4'hB

// ----------------------------------------------------------------------
// level_and_watchdog_control fields
// ----------------------------------------------------------------------
`define DIFL_MR0_WATCHDOG 7
`define DIFL_MR0_RX_LEVEL_HI 6
`define DIFL_MR0_TX_LEVEL_HI 5
`define DIFL_MR0_TX_LEVEL_LO 4
`define DIFL_MR0_UNUSED 3
`define DIFL_MR0_BAUD_HI 2
`define DIFL_MR0_BAUD_LO 0
`define DIFL_BAUD_NORMAL 3'h0
`define DIFL_BAUD_EXT_ONE 3'h1
`define DIFL_BAUD_EXT_TWO 3'h4
`define DIFL_CHAN_B_MASK 8'hF0

// ----------------------------------------------------------------------
// irq_status / irq_mask bit positions
// ----------------------------------------------------------------------
`define DIFL_IRQ_TX_A 0
`define DIFL_IRQ_RX_A 1
`define DIFL_IRQ_BREAK_A 2
`define DIFL_IRQ_COUNTER 3
`define DIFL_IRQ_TX_B 4
`define DIFL_IRQ_RX_B 5
`define DIFL_IRQ_BREAK_B 6
`define DIFL_IRQ_INPUT_CHANGE 7

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define DIFL_RST_MR0 8'h00
`define DIFL_RST_MASK 8'h00
`define DIFL_RST_PRELOAD 16'h0000
`define DIFL_FIFO_DEPTH 8
`define DIFL_WATCHDOG_BIT_TIMES 64

`endif

//--- verilog/difl_fifo_level.sv
// fill-level threshold decode for one channel
`timescale 1ns/10ps
`include "difl_consts.svh"

module difl_fifo_level #(
    parameter int DEPTH = `DIFL_FIFO_DEPTH
) (
    input wire logic [3:0] rx_count,
    input wire logic [3:0] tx_count,
    input wire logic [1:0] rx_code,
    input wire logic [1:0] tx_code,
    output logic rx_hit,
    output logic tx_hit
);
    localparam logic [3:0] FULL = 4'(DEPTH);
    localparam logic [3:0] HALF = 4'(DEPTH / 2);
    localparam logic [3:0] SIX = 4'h6;
    localparam logic [3:0] THREE = 4'h3;

    logic [3:0] tx_empty;

    always_comb begin
        tx_empty = FULL - tx_count;
        unique case (rx_code)
            2'h0: rx_hit = rx_count >= 4'h1;
            2'h1: rx_hit = rx_count >= THREE;
            2'h2: rx_hit = rx_count >= SIX;
            2'h3: rx_hit = rx_count == FULL;
        endcase
        unique case (tx_code)
            2'h0: tx_hit = tx_empty == FULL;
            2'h1: tx_hit = tx_empty >= HALF;
            2'h2: tx_hit = tx_empty >= SIX;
            2'h3: tx_hit = tx_empty >= 4'h1;
        endcase
    end
endmodule

//--- verilog/difl_pkg.sv
// types shared by the fifo-level interrupt block
package difl_pkg;

    // mode register select pointer of one channel
    typedef enum logic [1:0] {
        PTR_MR0,
        PTR_MR1,
        PTR_MR2
    } difl_ptr_type;

    // per-channel signals from the serial data path
    typedef struct packed {
        logic [3:0] rx_count;
        logic [3:0] tx_count;
        logic tx_enable;
        logic rx_fifo_access;
        logic rx_bit_tick;
        logic break_change;
        logic rx_level_lsb;
        logic ptr_to_mr0;
        logic ptr_to_mr1;
    } difl_chan_in_type;

    // per-channel results toward the data path
    typedef struct packed {
        logic rx_irq_req;
        logic tx_irq_req;
        logic [2:0] baud_group;
        logic watchdog_on;
    } difl_chan_out_type;

    typedef struct packed {
        logic [6:0] count;
        logic fired;
    } difl_wdog_state_type;

endpackage

//--- verilog/difl_rx_watchdog.sv
// receiver watchdog: timeout after idle bit times with data held
`timescale 1ns/10ps
`include "difl_consts.svh"

module difl_rx_watchdog #(
    parameter int BIT_TIMES = `DIFL_WATCHDOG_BIT_TIMES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic fifo_not_empty,
    input wire logic fifo_access,
    input wire logic bit_tick,
    output logic timeout
);
    localparam logic [6:0] LIMIT = 7'(BIT_TIMES);

    difl_pkg::difl_wdog_state_type state_reg;
    difl_pkg::difl_wdog_state_type state_next;

    always_comb begin
        state_next = state_reg;
        // any access restarts the idle window; disabled or empty holds off
        if (!enable || !fifo_not_empty || fifo_access) begin
            state_next.count = 7'h00;
            state_next.fired = 1'b0;
        end else if (bit_tick && !state_reg.fired) begin
            state_next.count = state_reg.count + 7'h01;
            if (state_next.count == LIMIT) begin
                state_next.fired = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign timeout = state_reg.fired;
endmodule

//--- verilog/difl_top.sv
// interrupt sources, fifo levels and preload registers of the dual uart
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`include "difl_consts.svh"

//
// Contract
// - mode register zero reached when pointer is zero
// - watchdog interrupts after 64 idle bit times
// - two-bit receive threshold: 1, 3, 6, 8
// - reset: receive threshold one or more bytes
// - transmit threshold counts empty slots: 8,4,6,1
// - transmit request asserts once transmitter enabled
// - code 00 drops request after one byte
// - low three bits pick baud group 000/001
// - group 100 extended two; channel B low unused
// - char format bit 6 is receive code low
// - preload high at 0x06, low at 0x07
module difl_top #(
    parameter int CHANNELS = 2,
    parameter int DEPTH = `DIFL_FIFO_DEPTH,
    parameter int BIT_TIMES = `DIFL_WATCHDOG_BIT_TIMES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire difl_pkg::difl_chan_in_type chan_in [CHANNELS],
    input wire logic [3:0] change_input,
    input wire logic counter_ready,
    output difl_pkg::difl_chan_out_type chan_out [CHANNELS],
    output logic [15:0] count_preload,
    output logic irq
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0][7:0] mr0;
        logic [1:0][1:0] ptr;
        logic [3:0] ip_prev;
        logic ip_valid;
        logic [3:0] delta;
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] preload_high;
        logic [7:0] preload_low;
        logic [7:0] rdata;
        logic [1:0] rx_req;
        logic [1:0] tx_req;
        logic irq;
    } difl_state_type;

    difl_state_type state_reg;
    difl_state_type state_next;

    logic [CHANNELS-1:0] rx_hit;
    logic [CHANNELS-1:0] tx_hit;
    logic [CHANNELS-1:0] wdog_timeout;
    logic [CHANNELS-1:0] mode_sel;

    // ------------------------------------------------------------------
    // per-channel threshold decode and watchdog
    // ------------------------------------------------------------------
    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
            logic [1:0] rx_code;
            logic [1:0] tx_code;
            // high bit from mode register zero, low bit from char format
            assign rx_code = {state_reg.mr0[ch][`DIFL_MR0_RX_LEVEL_HI],
                chan_in[ch].rx_level_lsb};
            assign tx_code = {state_reg.mr0[ch][`DIFL_MR0_TX_LEVEL_HI],
                state_reg.mr0[ch][`DIFL_MR0_TX_LEVEL_LO]};
            assign mode_sel[ch] = reg_addr ==
                ((ch == 0) ? `DIFL_OFF_MODE_A : `DIFL_OFF_MODE_B);

            difl_fifo_level #(
                .DEPTH(DEPTH)
            ) u_level (
                .rx_count(chan_in[ch].rx_count),
                .tx_count(chan_in[ch].tx_count),
                .rx_code(rx_code),
                .tx_code(tx_code),
                .rx_hit(rx_hit[ch]),
                .tx_hit(tx_hit[ch])
            );

            difl_rx_watchdog #(
                .BIT_TIMES(BIT_TIMES)
            ) u_wdog (
                .clk(clk),
                .reset(reset),
                .enable(state_reg.mr0[ch][`DIFL_MR0_WATCHDOG]),
                .fifo_not_empty(chan_in[ch].rx_count != 4'h0),
                .fifo_access(chan_in[ch].rx_fifo_access),
                .bit_tick(chan_in[ch].rx_bit_tick),
                .timeout(wdog_timeout[ch])
            );

            assign chan_out[ch].rx_irq_req = state_reg.rx_req[ch];
            assign chan_out[ch].tx_irq_req = state_reg.tx_req[ch];
            assign chan_out[ch].baud_group =
                state_reg.mr0[ch][`DIFL_MR0_BAUD_HI:`DIFL_MR0_BAUD_LO];
            assign chan_out[ch].watchdog_on =
                state_reg.mr0[ch][`DIFL_MR0_WATCHDOG];
        end
    endgenerate

    // ------------------------------------------------------------------
    // mode register write filter
    // ------------------------------------------------------------------
    function automatic logic [7:0] mr0_write(
        input logic [7:0] old_val,
        input logic [7:0] wdata,
        input logic chan_b
    );
        logic [7:0] val;
        logic [2:0] grp;
        val = wdata;
        grp = wdata[`DIFL_MR0_BAUD_HI:`DIFL_MR0_BAUD_LO];
        // no function behind this bit; keep it zero whatever is sent
        val[`DIFL_MR0_UNUSED] = 1'b0;
        // forbidden group codes leave the old group in place
        if (grp != `DIFL_BAUD_NORMAL && grp != `DIFL_BAUD_EXT_ONE &&
            grp != `DIFL_BAUD_EXT_TWO) begin
            val[`DIFL_MR0_BAUD_HI:`DIFL_MR0_BAUD_LO] =
                old_val[`DIFL_MR0_BAUD_HI:`DIFL_MR0_BAUD_LO];
        end
        if (chan_b) begin
            val = val & `DIFL_CHAN_B_MASK;
        end
        return val;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] events;
        logic [7:0] w1c;
        logic [3:0] ip_change;
        logic input_change_status_read;
        logic [1:0] rx_now;
        logic [1:0] tx_now;
        events = 8'h00;
        w1c = 8'h00;
        ip_change = 4'h0;
        input_change_status_read = 1'b0;
        rx_now = 2'h0;
        tx_now = 2'h0;
        state_next = state_reg;
        state_next.rdata = 8'h00;

        // request levels; tx only once the transmitter runs
        for (int ch = 0; ch < CHANNELS; ch++) begin
            rx_now[ch] = rx_hit[ch] || wdog_timeout[ch];
            tx_now[ch] = tx_hit[ch] && chan_in[ch].tx_enable;
        end
        state_next.rx_req = rx_now;
        state_next.tx_req = tx_now;

        // change detect; first sample after reset only seeds history
        state_next.ip_prev = change_input;
        state_next.ip_valid = 1'b1;
        if (state_reg.ip_valid) begin
            ip_change = change_input ^ state_reg.ip_prev;
        end

        events[`DIFL_IRQ_TX_A] = tx_now[0];
        events[`DIFL_IRQ_RX_A] = rx_now[0];
        events[`DIFL_IRQ_BREAK_A] = chan_in[0].break_change;
        events[`DIFL_IRQ_COUNTER] = counter_ready;
        events[`DIFL_IRQ_TX_B] = tx_now[1];
        events[`DIFL_IRQ_RX_B] = rx_now[1];
        events[`DIFL_IRQ_BREAK_B] = chan_in[1].break_change;
        events[`DIFL_IRQ_INPUT_CHANGE] = |ip_change;

        // pointer commands from the command decoder
        for (int ch = 0; ch < CHANNELS; ch++) begin
            if (chan_in[ch].ptr_to_mr0) begin
                state_next.ptr[ch] = 2'(difl_pkg::PTR_MR0);
            end else if (chan_in[ch].ptr_to_mr1) begin
                state_next.ptr[ch] = 2'(difl_pkg::PTR_MR1);
            end
        end

        // register writes
        if (reg_wr) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (mode_sel[ch]) begin
                    // zero goes to mr1, mr1 to mr2, mr2 stays
                    if (state_reg.ptr[ch] == 2'(difl_pkg::PTR_MR0)) begin
                        state_next.mr0[ch] = mr0_write(state_reg.mr0[ch],
                            reg_wdata, ch != 0);
                        state_next.ptr[ch] = 2'(difl_pkg::PTR_MR1);
                    end else begin
                        state_next.ptr[ch] = 2'(difl_pkg::PTR_MR2);
                    end
                end
            end
            unique case (reg_addr)
                `DIFL_OFF_IRQ: state_next.mask = reg_wdata;
                `DIFL_OFF_PRELOAD_HIGH: begin
                    state_next.preload_high = reg_wdata;
                end
                `DIFL_OFF_PRELOAD_LOW: begin
                    state_next.preload_low = reg_wdata;
                end
                `DIFL_OFF_IRQ_CLEAR: w1c = reg_wdata;
                default: ;
            endcase
        end

        // register reads; data stands one cycle after the strobe
        if (reg_rd) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (mode_sel[ch]) begin
                    // other pointer values belong to mr1/mr2 outside
                    if (state_reg.ptr[ch] == 2'(difl_pkg::PTR_MR0)) begin
                        state_next.rdata = state_reg.mr0[ch];
                        state_next.ptr[ch] = 2'(difl_pkg::PTR_MR1);
                    end else begin
                        state_next.ptr[ch] = 2'(difl_pkg::PTR_MR2);
                    end
                end
            end
            unique case (reg_addr)
                `DIFL_OFF_INPUT_CHANGE: begin
                    state_next.rdata = {state_reg.delta,
                        change_input};
                    input_change_status_read = 1'b1;
                end
                `DIFL_OFF_IRQ: state_next.rdata = state_reg.status;
                `DIFL_OFF_MASK_READ: state_next.rdata = state_reg.mask;
                default: ;
            endcase
        end

        // change flags: reading clears, a change in that cycle wins
        if (input_change_status_read) begin
            state_next.delta = ip_change;
        end else begin
            state_next.delta = state_reg.delta | ip_change;
        end

        // sticky status: set wins over write-one-to-clear
        state_next.status = (state_reg.status & ~w1c) | events;

        // level output from the next copy so it matches the flops
        state_next.irq = |(state_next.status & state_next.mask);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // empty fifos and code 00 select the one-byte threshold
            state_reg <= '0;
            state_reg.mr0 <= {2{`DIFL_RST_MR0}};
            state_reg.ptr <= {2{2'(difl_pkg::PTR_MR1)}};
            state_reg.mask <= `DIFL_RST_MASK;
            state_reg.preload_high <= 8'(`DIFL_RST_PRELOAD >> 8);
            state_reg.preload_low <= 8'(`DIFL_RST_PRELOAD);
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign count_preload = {state_reg.preload_high, state_reg.preload_low};
    assign irq = state_reg.irq;
endmodule
